/* verilog/seq_pkg.sv */
// Shared constants, types and decode functions for the bus cycle sequencer.
package seq_pkg;

    // ************************************************************
    // Bus constants
    // ************************************************************
    localparam logic [15:0] DEAD_CYCLE_ADDR = 16'hffff;
    localparam logic [7:0]  DIRECT_PAGE     = 8'h00;
    localparam logic [2:0]  MODE_SHOW_ALL   = 3'h0;

    // ************************************************************
    // Condition code layout and reset values
    // ************************************************************
    localparam int unsigned CC_C = 0;
    localparam int unsigned CC_V = 1;
    localparam int unsigned CC_Z = 2;
    localparam int unsigned CC_N = 3;
    localparam int unsigned CC_I = 4;
    localparam int unsigned CC_H = 5;
    localparam logic [7:0]  CC_RESET = 8'hd0;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;

    // ************************************************************
    // Opcode groups
    // ************************************************************
    localparam logic [3:0] BANK_IMM_A = 4'h8;
    localparam logic [3:0] BANK_DIR_A = 4'h9;
    localparam logic [3:0] BANK_IMM_B = 4'hc;
    localparam logic [3:0] BANK_DIR_B = 4'hd;
    localparam logic [7:0] OP_SUBROUTINE_CALL = 8'h9d;
    localparam logic [7:0] OP_STORE_DOUBLE    = 8'hdd;

    typedef enum logic [2:0] {
        CL_NONE, CL_ALU8, CL_STA, CL_LD16, CL_ST16, CL_AR16, CL_JSR
    } iclass_t;

    typedef enum logic [1:0] {R_D, R_X, R_S} reg16_t;

    typedef enum logic [2:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR, ALU_LD
    } alu_op_t;

    function automatic logic in_bank(input logic [7:0] op);
        return op[7:4] == BANK_IMM_A || op[7:4] == BANK_DIR_A ||
               op[7:4] == BANK_IMM_B || op[7:4] == BANK_DIR_B;
    endfunction

    function automatic logic is_imm(input logic [7:0] op);
        return !op[4];
    endfunction

    function automatic iclass_t op_class(input logic [7:0] op);
        iclass_t cl;
        cl = CL_NONE;
        if (in_bank(op)) begin
            case (op[3:0])
                4'h3: cl = CL_AR16;
                4'h7: cl = op[4] ? CL_STA : CL_NONE;
                4'hc: cl = op[6] ? CL_LD16 : CL_AR16;
                4'hd: begin
                    if (op == OP_SUBROUTINE_CALL) cl = CL_JSR;
                    else if (op == OP_STORE_DOUBLE) cl = CL_ST16;
                    else cl = CL_NONE;
                end
                4'he: cl = CL_LD16;
                4'hf: cl = op[4] ? CL_ST16 : CL_NONE;
                default: cl = CL_ALU8;
            endcase
        end
        return cl;
    endfunction

    function automatic reg16_t op_reg16(input logic [7:0] op);
        reg16_t r;
        case (op[3:0])
            4'hc: r = op[6] ? R_D : R_X;
            4'he,
            4'hf: r = op[6] ? R_X : R_S;
            default: r = R_D;
        endcase
        return r;
    endfunction

    function automatic alu_op_t op_alu(input logic [7:0] op);
        alu_op_t a;
        case (op[3:0])
            4'h0, 4'h1, 4'hc: a = ALU_SUB;
            4'h2: a = ALU_SBC;
            4'h3: a = op[6] ? ALU_ADD : ALU_SUB;
            4'h4, 4'h5: a = ALU_AND;
            4'h8: a = ALU_EOR;
            4'h9: a = ALU_ADC;
            4'ha: a = ALU_OR;
            4'hb: a = ALU_ADD;
            default: a = ALU_LD;
        endcase
        return a;
    endfunction

    // Compare and bit test only set flags.
    function automatic logic op_writes(input logic [7:0] op);
        return !(op[3:0] == 4'h1 || op[3:0] == 4'h5 || op[3:0] == 4'hc);
    endfunction

endpackage

/* verilog/mode_strap.sv */
// Synchroniser and one-time capture of the operating mode strap.
module mode_strap
    import seq_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    // Strap pins
    input  wire logic [2:0] mode_pins_in,
    // Captured mode
    output logic      [2:0] mode_out
);

    logic [2:0] meta;
    logic [2:0] stable;
    logic       taken;

    // ************************************************************
    // Two-stage synchroniser
    // ************************************************************
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta   <= 3'h0;
            stable <= 3'h0;
        end else begin
            meta   <= mode_pins_in;
            stable <= meta;
        end
    end

    // ************************************************************
    // Capture once after release
    // ************************************************************
    // The strap is caught after the synchroniser has filled, so the
    // value never depends on a port at reset time.
    // Until the strap is caught the mode reads as one that never echoes,
    // so no on-chip value leaks onto the pins in the first cycles.
    logic [1:0] fill;
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fill     <= 2'h0;
            taken    <= 1'b0;
            mode_out <= ~MODE_SHOW_ALL;
        end else begin
            fill <= {fill[0], 1'b1};
            if (fill[1] && !taken) begin
                taken    <= 1'b1;
                mode_out <= stable;
            end
        end
    end

endmodule

/* verilog/flag_unit.sv */
// Arithmetic and logic unit producing result and condition flags.
module flag_unit
    import seq_pkg::*;
(
    // Operation
    input  alu_op_t           op_in,
    input  wire logic         wide_in,
    input  wire logic         c_in,
    // Operands
    input  wire logic [15:0]  a_in,
    input  wire logic [15:0]  m_in,
    // Result and flags
    output logic      [15:0]  res_out,
    output logic              h_out,
    output logic              n_out,
    output logic              z_out,
    output logic              v_out,
    output logic              c_out
);

    logic [16:0] sum;
    logic        cin;
    logic        ma;
    logic        mm;
    logic        mr;

    always_comb begin
        cin = (op_in == ALU_ADC || op_in == ALU_SBC) ? c_in : 1'b0;
        case (op_in)
            ALU_ADD, ALU_ADC: sum = {1'b0, a_in} + {1'b0, m_in} + {16'h0000, cin};
            ALU_SUB, ALU_SBC: sum = {1'b0, a_in} - {1'b0, m_in} - {16'h0000, cin};
            ALU_AND: sum = {1'b0, a_in & m_in};
            ALU_OR:  sum = {1'b0, a_in | m_in};
            ALU_EOR: sum = {1'b0, a_in ^ m_in};
            default: sum = {1'b0, m_in};
        endcase
        res_out = wide_in ? sum[15:0] : {8'h00, sum[7:0]};
        ma = wide_in ? a_in[15] : a_in[7];
        mm = wide_in ? m_in[15] : m_in[7];
        mr = wide_in ? sum[15] : sum[7];
        h_out = a_in[4] ^ m_in[4] ^ sum[4];
        n_out = mr;
        z_out = res_out == 16'h0000;
        case (op_in)
            ALU_ADD, ALU_ADC: v_out = (ma == mm) && (mr != ma);
            ALU_SUB, ALU_SBC: v_out = (ma != mm) && (mr != ma);
            default: v_out = 1'b0;
        endcase
        c_out = wide_in ? sum[16] : sum[8];
    end

endmodule

/* verilog/bus_cycle_sequencer.sv */
// Per-cycle bus sequencer for immediate and direct addressing modes.
module bus_cycle_sequencer
    import seq_pkg::*;
#(
    parameter logic [15:0] ONCHIP_LO = 16'h0000,
    parameter logic [15:0] ONCHIP_HI = 16'h00ff
)(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    // External bus
    output logic      [15:0] addr_out,
    output logic             rw_out,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe_out,
    // On-chip resources
    input  wire logic [7:0]  int_rdata_in,
    // Mode strap
    input  wire logic [2:0]  mode_pins_in,
    // Status
    output logic      [7:0]  cc_out,
    output logic             fetch_out
);

    if (ONCHIP_HI < ONCHIP_LO) begin : g_range_check
        $error("on-chip range is empty");
    end

    typedef enum logic [3:0] {
        S_FETCH, S_IMM8, S_IMM_HI, S_IMM_LO, S_DIR, S_RD8, S_WR8, S_RD_HI,
        S_RD_LO, S_DEAD, S_WR_HI, S_WR_LO, S_SUB, S_PUSH_LO, S_PUSH_HI
    } state_t;

    state_t      state;
    state_t      next_state;
    logic [7:0]  opcode;
    logic [7:0]  acc_a;
    logic [7:0]  acc_b;
    logic [15:0] idx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] ea;
    logic [7:0]  data_hi;
    logic [15:0] opnd16;
    logic [15:0] next_pc;
    logic [15:0] next_ea;
    logic [15:0] next_sp;
    logic [15:0] next_addr;
    logic        next_rw;
    logic [7:0]  next_wdata;
    logic [2:0]  mode;
    logic        onchip;
    logic [7:0]  rd;
    logic        echo;
    iclass_t     cls;
    iclass_t     fetch_cls;
    reg16_t      rsel;
    logic [15:0] reg16;
    logic [7:0]  acc;
    alu_op_t     fu_op;
    logic        fu_wide;
    logic [15:0] fu_a;
    logic [15:0] fu_m;
    logic [15:0] fu_res;
    logic        fu_h;
    logic        fu_n;
    logic        fu_z;
    logic        fu_v;
    logic        fu_c;

    mode_strap u_strap (
        .clock_in     (clock_in),
        .rst_b_in     (rst_b_in),
        .mode_pins_in (mode_pins_in),
        .mode_out     (mode)
    );

    // ************************************************************
    // Decode
    // ************************************************************
    assign onchip    = addr_out >= ONCHIP_LO && addr_out <= ONCHIP_HI;
    assign rd        = onchip ? int_rdata_in : data_in;
    assign fetch_cls = op_class(rd);
    assign cls       = op_class(opcode);
    assign rsel      = op_reg16(opcode);
    assign acc       = opcode[6] ? acc_b : acc_a;

    always_comb begin
        case (rsel)
            R_X:     reg16 = idx;
            R_S:     reg16 = sp;
            default: reg16 = {acc_a, acc_b};
        endcase
    end

    // ************************************************************
    // Cycle sequencing
    // ************************************************************
    // Sequences are chosen by addressing mode and class only, so every
    // opcode of one group walks the same bus cycles.
    always_comb begin
        next_state = S_FETCH;
        next_pc    = pc;
        next_ea    = ea;
        next_sp    = sp;
        case (state)
            S_FETCH: begin
                next_pc = pc + 16'h0001;
                if (fetch_cls == CL_NONE) next_state = S_FETCH;
                else if (!is_imm(rd)) next_state = S_DIR;
                else if (fetch_cls == CL_ALU8) next_state = S_IMM8;
                else if (fetch_cls == CL_LD16 || fetch_cls == CL_AR16) begin
                    next_state = S_IMM_HI;
                end else next_state = S_FETCH;
            end
            S_IMM8: next_pc = pc + 16'h0001;
            S_IMM_HI: begin
                next_pc    = pc + 16'h0001;
                next_state = S_IMM_LO;
            end
            S_IMM_LO: begin
                next_pc    = pc + 16'h0001;
                next_state = (cls == CL_AR16) ? S_DEAD : S_FETCH;
            end
            S_DIR: begin
                next_pc = pc + 16'h0001;
                next_ea = {DIRECT_PAGE, rd};
                case (cls)
                    CL_ALU8: next_state = S_RD8;
                    CL_STA:  next_state = S_WR8;
                    CL_LD16, CL_AR16: next_state = S_RD_HI;
                    CL_ST16: next_state = S_WR_HI;
                    CL_JSR:  next_state = S_SUB;
                    default: next_state = S_FETCH;
                endcase
            end
            S_RD_HI: begin
                next_ea    = ea + 16'h0001;
                next_state = S_RD_LO;
            end
            S_RD_LO: next_state = (cls == CL_AR16) ? S_DEAD : S_FETCH;
            S_WR_HI: begin
                next_ea    = ea + 16'h0001;
                next_state = S_WR_LO;
            end
            S_SUB: next_state = S_PUSH_LO;
            S_PUSH_LO: begin
                next_sp    = sp - 16'h0001;
                next_state = S_PUSH_HI;
            end
            S_PUSH_HI: begin
                next_sp = sp - 16'h0001;
                next_pc = ea;
            end
            default: next_state = S_FETCH;
        endcase
    end

    // One transfer per cycle: address, direction and write data follow
    // the cycle about to begin.
    always_comb begin
        next_rw    = 1'b1;
        next_wdata = 8'h00;
        case (next_state)
            S_RD8, S_RD_HI, S_RD_LO, S_SUB: next_addr = next_ea;
            S_DEAD: next_addr = DEAD_CYCLE_ADDR;
            S_WR8: begin
                next_addr  = next_ea;
                next_rw    = 1'b0;
                next_wdata = acc;
            end
            S_WR_HI: begin
                next_addr  = next_ea;
                next_rw    = 1'b0;
                next_wdata = reg16[15:8];
            end
            S_WR_LO: begin
                next_addr  = next_ea;
                next_rw    = 1'b0;
                next_wdata = reg16[7:0];
            end
            S_PUSH_LO: begin
                next_addr  = next_sp;
                next_rw    = 1'b0;
                next_wdata = next_pc[7:0];
            end
            S_PUSH_HI: begin
                next_addr  = next_sp;
                next_rw    = 1'b0;
                next_wdata = next_pc[15:8];
            end
            default: next_addr = next_pc;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= S_FETCH;
            pc    <= PC_RESET;
            ea    <= 16'h0000;
        end else begin
            state <= next_state;
            pc    <= next_pc;
            ea    <= next_ea;
        end
    end

    // ************************************************************
    // Bus pins
    // ************************************************************
    // An on-chip read is shown on the pins one cycle late, and only in
    // mode 0; a following write cycle owns the bus and drops the echo.
    assign echo = rw_out && onchip && mode == MODE_SHOW_ALL;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            addr_out    <= PC_RESET;
            rw_out      <= 1'b1;
            data_out    <= 8'h00;
            data_oe_out <= 1'b0;
            fetch_out   <= 1'b1;
        end else begin
            addr_out    <= next_addr;
            rw_out      <= next_rw;
            data_out    <= next_rw ? (echo ? rd : 8'h00) : next_wdata;
            data_oe_out <= !next_rw || echo;
            fetch_out   <= next_state == S_FETCH;
        end
    end

    // ************************************************************
    // Operand capture
    // ************************************************************
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            opcode  <= 8'h00;
            data_hi <= 8'h00;
            opnd16  <= 16'h0000;
        end else begin
            if (state == S_FETCH) opcode <= rd;
            if (state == S_IMM_HI || state == S_RD_HI) data_hi <= rd;
            if (state == S_IMM_LO || state == S_RD_LO) opnd16 <= {data_hi, rd};
        end
    end

    // ************************************************************
    // Execution
    // ************************************************************
    always_comb begin
        fu_op   = ALU_LD;
        fu_wide = 1'b1;
        fu_a    = reg16;
        fu_m    = reg16;
        case (cls)
            CL_ALU8: begin
                fu_op   = op_alu(opcode);
                fu_wide = 1'b0;
                fu_a    = {8'h00, acc};
                fu_m    = {8'h00, rd};
            end
            CL_STA: begin
                fu_wide = 1'b0;
                fu_m    = {8'h00, acc};
            end
            CL_LD16: fu_m = {data_hi, rd};
            CL_AR16: begin
                fu_op = op_alu(opcode);
                fu_m  = opnd16;
            end
            default: fu_m = reg16;
        endcase
    end

    flag_unit u_flags (
        .op_in   (fu_op),
        .wide_in (fu_wide),
        .c_in    (cc_out[CC_C]),
        .a_in    (fu_a),
        .m_in    (fu_m),
        .res_out (fu_res),
        .h_out   (fu_h),
        .n_out   (fu_n),
        .z_out   (fu_z),
        .v_out   (fu_v),
        .c_out   (fu_c)
    );

    logic exec8;
    logic exec_ld16;
    logic exec_ar16;
    logic exec_st;
    logic arith;
    assign exec8     = (state == S_IMM8 || state == S_RD8) && cls == CL_ALU8;
    assign exec_ld16 = (state == S_IMM_LO || state == S_RD_LO) && cls == CL_LD16;
    assign exec_ar16 = state == S_DEAD;
    assign exec_st   = state == S_WR8 || state == S_WR_HI;
    assign arith     = fu_op == ALU_ADD || fu_op == ALU_ADC ||
                       fu_op == ALU_SUB || fu_op == ALU_SBC;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cc_out <= CC_RESET;
        end else if (exec8 || exec_ld16 || exec_ar16 || exec_st) begin
            cc_out[CC_N] <= fu_n;
            cc_out[CC_Z] <= fu_z;
            cc_out[CC_V] <= fu_v;
            if (arith) cc_out[CC_C] <= fu_c;
            if (exec8 && (fu_op == ALU_ADD || fu_op == ALU_ADC)) begin
                cc_out[CC_H] <= fu_h;
            end
        end
    end

    // The dead cycle's data is ignored; the result comes from the
    // operand captured in the two cycles before it.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            acc_a <= 8'h00;
            acc_b <= 8'h00;
            idx   <= 16'h0000;
            sp    <= SP_RESET;
        end else begin
            if (exec8 && op_writes(opcode)) begin
                if (opcode[6]) acc_b <= fu_res[7:0];
                else acc_a <= fu_res[7:0];
            end
            if (exec_ld16 || (exec_ar16 && op_writes(opcode))) begin
                case (rsel)
                    R_X: idx <= fu_res;
                    R_S: sp  <= fu_res;
                    default: begin
                        acc_a <= fu_res[15:8];
                        acc_b <= fu_res[7:0];
                    end
                endcase
            end else begin
                sp <= next_sp;
            end
        end
    end

endmodule

/* tb/seq_chk.sv */
// Concurrent checks on the bus cycle sequencer ports.
module seq_chk
    import seq_pkg::*;
#(
    parameter logic [15:0] ONCHIP_LO = 16'h0000,
    parameter logic [15:0] ONCHIP_HI = 16'h00ff
)(
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic [15:0] addr_out,
    input  wire logic        rw_out,
    input  wire logic [7:0]  data_in,
    input  wire logic        data_oe_out,
    input  wire logic [7:0]  int_rdata_in,
    input  wire logic [2:0]  mode_pins_in,
    input  wire logic        fetch_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rd;
    logic [2:0] age;
    assign rd = (addr_out >= ONCHIP_LO && addr_out <= ONCHIP_HI) ? int_rdata_in : data_in;
    // The strap settles a few edges after reset, so echo checks wait for it.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) age <= 3'h0;
        else if (age != 3'h7) age <= age + 3'h1;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    sequence step_s;
        rw_out && addr_out == $past(addr_out) + 16'h1;
    endsequence
    sequence page_s;
        addr_out == {DIRECT_PAGE, $past(rd)};
    endsequence
    write_drive_a: assert property (!rw_out |-> data_oe_out)
        else $error("write not driven");
    no_echo_a: assert property ((age == 3'h7 && mode_pins_in != MODE_SHOW_ALL && rw_out)
        |-> !data_oe_out) else $error("on-chip read echoed");
    write_pair_a: assert property ((!rw_out ##1 !rw_out) |=> rw_out)
        else $error("more than two writes");
    dead_fetch_a: assert property ((rw_out && addr_out == DEAD_CYCLE_ADDR) |=> fetch_out)
        else $error("no fetch after dead cycle");
    imm_byte_a: assert property ((fetch_out && rd == 8'h8b) |=> step_s ##1 fetch_out)
        else $error("immediate byte op length");
    imm_load_a: assert property ((fetch_out && rd == 8'hcc) |=> step_s [*2] ##1 fetch_out)
        else $error("immediate wide load");
    imm_arith_a: assert property ((fetch_out && rd == 8'hc3) |=> step_s [*2]
        ##1 (rw_out && addr_out == DEAD_CYCLE_ADDR) ##1 fetch_out) else $error("wide add");
    dir_load_a: assert property ((fetch_out && rd == 8'h9e) |=> step_s ##1 page_s
        ##1 step_s ##1 fetch_out) else $error("direct wide load");
    dir_store_a: assert property ((fetch_out && rd == 8'hdd) |=> step_s ##1 (page_s ##0 !rw_out)
        ##1 (!rw_out && addr_out == $past(addr_out) + 16'h1) ##1 fetch_out) else $error("store");
    call_seq_a: assert property ((fetch_out && rd == 8'h9d) |=> step_s ##1 (page_s ##0 rw_out)
        ##1 !rw_out ##1 (!rw_out && addr_out == $past(addr_out) - 16'h1)
        ##1 (fetch_out && addr_out == $past(addr_out, 3))) else $error("call sequence");
endmodule

/* tb/mem_model.sv */
// Memory and peripherals on the far side of the bus.
module mem_model (
    input  wire logic        clock_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        rw_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        oe_in,
    output logic      [7:0]  ext_rdata_out,
    output logic      [7:0]  int_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h5a;
    assign int_rdata_out = mem[addr_in];
    // No wait states; an idle line shows the inverse of its last value, never a stale copy.
    assign ext_rdata_out = (rw_in && addr_in > 16'h00ff) ? mem[addr_in] : ~last;
    always @(posedge clock_in) begin
        last <= ext_rdata_out;
        if (!rw_in && oe_in) mem[addr_in] <= wdata_in;
    end
endmodule

/* tb/cpu_bus_cycle_sequencer_bench.sv */
// Self-checking bench for the bus cycle sequencer.
module cpu_bus_cycle_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in     = 1'b0;
    logic        rst_b_in     = 1'b0;
    logic [2:0]  mode_pins_in = 3'h2;
    logic [15:0] addr_out;
    logic        rw_out;
    logic        data_oe_out;
    logic        fetch_out;
    logic [7:0]  data_in;
    logic [7:0]  data_out;
    logic [7:0]  int_rdata_in;
    logic [7:0]  cc_out;
    int          failures = 0;
    int          n_tests  = 0;
    int          cycles   = 0;
    logic [7:0]  prog [22] = '{8'h86, 8'h7f, 8'h8b, 8'h01, 8'hcc, 8'h12, 8'h34, 8'hc3, 8'hf0,
        8'h00, 8'hdd, 8'h40, 8'h9d, 8'h50, 8'h9e, 8'h56, 8'h9f, 8'h70, 8'h00, 8'h00, 8'hab, 8'hcd};
    // Row: address, read flag, write data, expected flags (zero means not looked at).
    logic [35:0] rows [29] = '{36'h000010000, 36'h000110000, 36'h000210000, 36'h000310000,
        36'h0004100fa, 36'h000510000, 36'h000610000, 36'h0007100f0, 36'h000810000,
        36'h000910000, 36'hffff10000, 36'h000a100f1, 36'h000b10000, 36'h004000200,
        36'h004103400, 36'h000c10000, 36'h000d10000, 36'h005010000, 36'h000000e00,
        36'hffff00000, 36'h005010000, 36'h005110000, 36'h005610000, 36'h005710000,
        36'h0052100f9, 36'h005310000, 36'h00700ab00, 36'h00710cd00, 36'h005410000};
    bus_cycle_sequencer u_bus_cycle_sequencer (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .addr_out(addr_out), .rw_out(rw_out), .data_in(data_in), .data_out(data_out),
        .data_oe_out(data_oe_out), .int_rdata_in(int_rdata_in), .mode_pins_in(mode_pins_in),
        .cc_out(cc_out), .fetch_out(fetch_out));
    mem_model u_mem_model (.clock_in(clock_in), .addr_in(addr_out), .rw_in(rw_out),
        .wdata_in(data_out), .oe_in(data_oe_out), .ext_rdata_out(data_in),
        .int_rdata_out(int_rdata_in));
    always #2.5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            final_report();
        end
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // *****************************************************
    // Reset, program load and one traced run, in mode 2 and then in mode 0.
    // *****************************************************
    task run(input logic [2:0] m);
        @(posedge clock_in);
        #1;
        rst_b_in = 1'b0;
        mode_pins_in = m;
        for (int a = 0; a < 65536; a++) u_mem_model.mem[a] = 8'h00;
        for (int a = 0; a < 22; a++) u_mem_model.mem[a < 14 ? a : a + 16'h42] = prog[a];
        @(negedge clock_in);
        check({addr_out[11:0], rw_out, data_oe_out, fetch_out, 1'b0}, 16'h000a);
        check({8'h00, cc_out}, 16'h00d0);
        repeat (2) @(posedge clock_in);
        #1;
        rst_b_in = 1'b1;
        for (int i = 0; i < 29; i++) begin
            @(negedge clock_in);
            check(addr_out, rows[i][35:20]);
            check({15'h0, rw_out}, {15'h0, rows[i][16]});
            if (!rows[i][16]) check({8'h0, data_out}, {8'h0, rows[i][15:8]});
            else if (m != 3'h0) check({15'h0, data_oe_out}, 16'h0);
            if (rows[i][7:0] != 8'h00) check({8'h0, cc_out}, {8'h0, rows[i][7:0]});
            if (m == 3'h0 && i == 5) check({7'h0, data_oe_out, data_out}, 16'h01cc);
        end
        $display("run in mode %0d done", m);
    endtask
    initial begin
        run(3'h2);
        run(3'h0);
        final_report();
    end
endmodule
bind bus_cycle_sequencer seq_chk #(.ONCHIP_LO(ONCHIP_LO), .ONCHIP_HI(ONCHIP_HI)) u_seq_chk (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_out(addr_out), .rw_out(rw_out),
    .data_in(data_in), .data_oe_out(data_oe_out), .int_rdata_in(int_rdata_in),
    .mode_pins_in(mode_pins_in), .fetch_out(fetch_out));
